// ===== hdl/dms_pkg.sv
// constants and types of the data map, accumulator and status block
package dms_pkg;

    // ***************************************
    // data map
    // ***************************************
    localparam logic [15:0] RAM_LO     = 16'h0200;
    localparam logic [15:0] RAM_HI     = 16'h09ff;
    localparam logic [15:0] RAM_HI_SM  = 16'h05ff;
    localparam logic [15:0] PR_HI      = 16'h023f;
    localparam logic [15:0] SBA_LO     = 16'h02c0;
    localparam logic [15:0] SBA_HI     = 16'h02ff;
    localparam logic [15:0] WIN_LO     = 16'h1000;

    // ***************************************
    // status word bits
    // ***************************************
    localparam int B_CY  = 15;
    localparam int B_ZF  = 14;
    localparam int B_HC  = 13;
    localparam int B_DD  = 12;
    localparam int B_S   = 11;
    localparam int B_OV  = 9;
    localparam int B_MIE = 8;

    // ***************************************
    // register offsets and resets
    // ***************************************
    localparam logic [7:0]  OFS_ACC  = 8'h00;
    localparam logic [7:0]  OFS_PSW  = 8'h04;
    localparam logic [7:0]  OFS_LRB  = 8'h08;
    localparam logic [7:0]  OFS_CTRL = 8'h0c;
    localparam logic [7:0]  OFS_STAT = 8'h10;
    localparam logic [7:0]  OFS_STATUS_HIGH_BYTE = 8'h14;
    localparam logic [7:0]  OFS_STATUS_LOW_BYTE = 8'h18;
    localparam logic [15:0] RST_ACC  = 16'h0000;
    localparam logic [15:0] RST_PSW  = 16'h0000;

    // ***************************************
    // timing
    // ***************************************
    localparam int CLK_KHZ  = 25000;
    localparam int STRB_NS  = 160;
    localparam int STRB_CYC = (STRB_NS * CLK_KHZ + 999999) / 1000000;

    // ***************************************
    // types
    // ***************************************
    typedef enum logic [4:0] {
        RG_LOW = 5'b00001,
        RG_PR  = 5'b00010,
        RG_SBA = 5'b00100,
        RG_RAM = 5'b01000,
        RG_EXT = 5'b10000
    } dms_region_e;

    typedef enum logic [3:0] {
        OP_ADD  = 4'h0,
        OP_SUB  = 4'h1,
        OP_CMP  = 4'h2,
        OP_AND  = 4'h3,
        OP_OR   = 4'h4,
        OP_XOR  = 4'h5,
        OP_LOAD = 4'h6,
        OP_SETC = 4'h7,
        OP_CLRC = 4'h8,
        OP_SETW = 4'h9,
        OP_CLRW = 4'ha,
        OP_BITT = 4'hb,
        OP_IRQ  = 4'hc,
        OP_RETI = 4'hd,
        OP_NOP  = 4'hf
    } dms_op_e;

    typedef enum logic [2:0] {
        XS_IDLE = 3'b001,
        XS_ALE  = 3'b010,
        XS_STRB = 3'b100
    } dms_xs_e;

    typedef struct packed {
        logic [15:0] res;
        logic        cy;
        logic        hc;
        logic        ov;
    } dms_alu_s;

endpackage

// ===== hdl/dms_core.sv
// data map decode, accumulator, status word and external bus
//
// Behaviour
// [RL1] internal ram is 0200h-09ffh, or 0200h-05ffh in the small variant
// [RL2] eight sets of four 16-bit pointers at 0200h-023fh, low byte even
// [RL3] 02c0h-02ffh is classed as the short bit area
// [RL4] local window base is 0200h plus local_base_low times eight
// [RL5] external area uses muxed address/data, high address, latch and strobes
// [RL6] window enabled: external reads at 1000h up return program memory
// [RL7] byte access uses the given address unchanged
// [RL8] data word access clears address bit zero, high byte at odd
// [RL9] program memory word access keeps any byte alignment
// [RL10] arith_register word uses 15..0, byte 7..0, nibble 3..0
// [RL11] bit from arith_register: bits 7..3 offset, bits 2..0 index
// [RL12] every reset source clears arith_register
// [RL13] status_word usable whole or as high and low bytes
// [RL14] every reset source clears status_word
// [RL15] interrupt entry saves status_word, interrupt_return restores it
// [RL16] loads and arithmetic on status_word may leave flags undefined
// [RL17] carry_flag from bit 7 or 15 carry or borrow, directly settable
// [RL18] zero_flag on zero result, zero load or zero tested bit
// [RL19] nibble_carry_flag on carry or borrow from bit 3
// [RL20] width_descriptor selects word or byte arithmetic and transfer
// [RL21] word load or set_width_instr sets, byte load or clear clears it
// [RL22] direct status write of width is seen one instruction later
// [RL23] pointer_set_select picks the 8-byte pointer set from 0200h
// [RL24] top_bit_flag follows the result msb
// [RL25] twos_range_exceeded on signed overflow of the operand width
`timescale 1ns/1ps

module dms_core #(
    parameter bit SMALL_RAM = 1'b0    // reduced internal ram variant
) (
    input  wire logic        clk_sys_i,     // system clock
    input  wire logic        rst_b_i,       // sync reset, low active
    input  wire logic        reset_src_i,   // break, watchdog or trap reset
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error
    input  wire logic        op_valid_i,    // instruction step
    input  wire logic [3:0]  op_code_i,     // operation code
    input  wire logic        op_word_i,     // load is word type
    input  wire logic [15:0] operand_i,     // second operand
    output logic      [15:0] result_o,      // last result
    output logic      [4:0]  bit_off_o,     // bit address offset
    output logic      [2:0]  bit_idx_o,     // bit position
    output logic      [3:0]  nibble_o,      // nibble view
    output logic             width_o,       // width seen by next op
    input  wire logic        dec_valid_i,   // address decode request
    input  wire logic [15:0] dec_addr_i,    // address to decode
    input  wire logic        dec_word_i,    // word access
    input  wire logic        dec_code_i,    // program memory access
    input  wire logic [2:0]  dec_sel_i,     // register number
    output logic      [4:0]  region_o,      // one-hot region
    output logic      [15:0] dec_addr_o,    // low byte address
    output logic      [15:0] dec_addr_hi_o, // high byte address
    output logic      [15:0] pr_addr_o,     // pointer low byte address
    output logic      [15:0] lr_addr_o,     // local register address
    input  wire logic        ext_req_i,     // external access request
    input  wire logic        ext_we_i,      // external write
    input  wire logic [15:0] ext_addr_i,    // external address
    input  wire logic [7:0]  ext_wdata_i,   // external write byte
    input  wire logic [7:0]  code_rdata_i,  // program memory byte
    output logic             ext_busy_o,    // external cycle running
    output logic             ext_done_o,    // access finished pulse
    output logic      [7:0]  ext_rdata_o,   // read byte
    input  wire logic [7:0]  mad_i,         // muxed_addr_data in
    output logic      [7:0]  mad_o,         // muxed_addr_data out
    output logic             mad_oe_o,      // muxed_addr_data drive
    output logic      [7:0]  high_addr_o,   // high_address pins
    output logic             ale_o,         // address latch strobe
    output logic             rd_b_o,        // read strobe, low active
    output logic             wr_b_o         // write strobe, low active
);

    // ***************************************
    // state
    // ***************************************
    typedef struct packed {
        logic [15:0]     acc;
        logic [15:0]     program_status_word;
        logic [15:0]     psw_save;
        logic [7:0]      local_base_low;
        logic            win_en;
        logic            pin_en;
        logic            dd_pend;
        logic            dd_old;
        logic [15:0]     res;
        logic [4:0]      region;
        logic [15:0]     daddr;
        logic [15:0]     daddr_hi;
        logic [15:0]     pr_addr;
        logic [15:0]     lr_addr;
        dms_pkg::dms_xs_e xs;
        logic [3:0]      xcnt;
        logic [15:0]     xaddr;
        logic            xwe;
        logic [7:0]      xwdata;
        logic [7:0]      xrdata;
        logic            xdone;
        logic [7:0]      sync1;
        logic [7:0]      sync2;
        logic [31:0]     rdata;
        logic            err;
    } dms_st_s;

    dms_st_s q;
    dms_st_s n;

    logic           dd_eff;
    logic           apb_wr;
    logic           win_rd;
    dms_pkg::dms_op_e op;
    dms_pkg::dms_alu_s alu;

    // ***************************************
    // functions
    // ***************************************

    // region of a data address
    function automatic logic [4:0] region_f(input logic [15:0] a);
        logic [15:0] top;
        top = SMALL_RAM ? dms_pkg::RAM_HI_SM : dms_pkg::RAM_HI;
        if (a < dms_pkg::RAM_LO) begin
            region_f = dms_pkg::RG_LOW;
        end else if (a <= dms_pkg::PR_HI) begin
            region_f = dms_pkg::RG_PR;           // [RL2]
        end else if (a >= dms_pkg::SBA_LO && a <= dms_pkg::SBA_HI) begin
            region_f = dms_pkg::RG_SBA;          // [RL3]
        end else if (a <= top) begin
            region_f = dms_pkg::RG_RAM;          // [RL1]
        end else begin
            region_f = dms_pkg::RG_EXT;          // [RL5]
        end
    endfunction

    // arithmetic and logic at the chosen width
    function automatic dms_pkg::dms_alu_s alu_f(
        input dms_pkg::dms_op_e o,
        input logic             w,
        input logic [15:0]      a,
        input logic [15:0]      b
    );
        logic [15:0] aw;
        logic [15:0] bw;
        logic [16:0] s;
        logic [4:0]  h;
        logic        sb;
        logic        am;
        logic        bm;
        logic        sm;
        dms_pkg::dms_alu_s r;
        aw = w ? a : {8'h00, a[7:0]};            // [RL10]
        bw = w ? b : {8'h00, b[7:0]};
        sb = (o == dms_pkg::OP_SUB) || (o == dms_pkg::OP_CMP);
        s  = sb ? {1'b0, aw} - {1'b0, bw} : {1'b0, aw} + {1'b0, bw};
        h  = sb ? {1'b0, aw[3:0]} - {1'b0, bw[3:0]} : {1'b0, aw[3:0]} + {1'b0, bw[3:0]};
        case (o)
            dms_pkg::OP_AND: s = {1'b0, aw & bw};
            dms_pkg::OP_OR:  s = {1'b0, aw | bw};
            dms_pkg::OP_XOR: s = {1'b0, aw ^ bw};
            default: s = s;
        endcase
        am = w ? aw[15] : aw[7];
        bm = w ? bw[15] : bw[7];
        sm = w ? s[15] : s[7];
        r.res = w ? s[15:0] : {a[15:8], s[7:0]};
        r.cy  = w ? s[16] : s[8];                // [RL17]
        r.hc  = h[4];                            // [RL19]
        r.ov  = sb ? (am != bm) && (sm != am) : (am == bm) && (sm != am); // [RL25]
        alu_f = r;
    endfunction

    // ***************************************
    // next state
    // ***************************************
    assign op     = dms_pkg::dms_op_e'(op_code_i);
    assign dd_eff = q.dd_pend ? q.dd_old : q.program_status_word[dms_pkg::B_DD]; // [RL22]
    assign alu    = alu_f(op, dd_eff, q.acc, operand_i);         // [RL20]
    assign apb_wr = psel && penable && pwrite;
    assign win_rd = q.win_en && !ext_we_i && (ext_addr_i >= dms_pkg::WIN_LO);

    always_comb begin
        n       = q;
        n.xdone = 1'b0;
        n.sync1 = mad_i;
        n.sync2 = q.sync1;

        // instruction step; status loads may leave flags undefined [RL16]
        if (op_valid_i) begin
            n.dd_pend = 1'b0;                    // [RL22]
            case (op)
                dms_pkg::OP_ADD, dms_pkg::OP_SUB, dms_pkg::OP_CMP,
                dms_pkg::OP_AND, dms_pkg::OP_OR, dms_pkg::OP_XOR: begin
                    if (op != dms_pkg::OP_CMP) begin
                        n.acc = alu.res;
                    end
                    n.res = alu.res;
                    if (op <= dms_pkg::OP_CMP) begin
                        n.program_status_word[dms_pkg::B_CY] = alu.cy; // [RL17]
                        n.program_status_word[dms_pkg::B_HC] = alu.hc; // [RL19]
                        n.program_status_word[dms_pkg::B_OV] = alu.ov; // [RL25]
                    end
                    n.program_status_word[dms_pkg::B_ZF] = dd_eff ? (alu.res == 16'h0000)
                                                  : (alu.res[7:0] == 8'h00); // [RL18]
                    n.program_status_word[dms_pkg::B_S]  = dd_eff ? alu.res[15] : alu.res[7]; // [RL24]
                end
                dms_pkg::OP_LOAD: begin
                    n.acc = op_word_i ? operand_i : {q.acc[15:8], operand_i[7:0]}; // [RL10]
                    n.res = n.acc;
                    n.program_status_word[dms_pkg::B_DD] = op_word_i; // [RL21]
                    n.program_status_word[dms_pkg::B_ZF] = op_word_i ? (operand_i == 16'h0000)
                                                     : (operand_i[7:0] == 8'h00); // [RL18]
                end
                dms_pkg::OP_SETC: n.program_status_word[dms_pkg::B_CY] = 1'b1; // [RL17]
                dms_pkg::OP_CLRC: n.program_status_word[dms_pkg::B_CY] = 1'b0; // [RL17]
                dms_pkg::OP_SETW: n.program_status_word[dms_pkg::B_DD] = 1'b1; // [RL21]
                dms_pkg::OP_CLRW: n.program_status_word[dms_pkg::B_DD] = 1'b0; // [RL21]
                dms_pkg::OP_BITT: begin
                    n.program_status_word[dms_pkg::B_ZF] = ~operand_i[q.acc[2:0]]; // [RL11] [RL18]
                end
                dms_pkg::OP_IRQ: begin
                    n.psw_save = q.program_status_word;          // [RL15]
                    n.program_status_word[dms_pkg::B_MIE] = 1'b0;
                end
                dms_pkg::OP_RETI: n.program_status_word = q.psw_save; // [RL15]
                default: n.res = q.res;
            endcase
        end

        // address decode, aligned pairs and register addresses
        if (dec_valid_i) begin
            n.region   = region_f(dec_addr_i);
            n.daddr    = (dec_word_i && !dec_code_i) ? {dec_addr_i[15:1], 1'b0}
                                                     : dec_addr_i; // [RL7] [RL8] [RL9]
            n.daddr_hi = n.daddr + 16'h0001;     // [RL8] [RL9]
            n.pr_addr  = {6'h00, 1'b1, 3'h0, q.program_status_word[2:0], dec_sel_i[1:0], 1'b0}; // [RL2] [RL23]
            n.lr_addr  = dms_pkg::RAM_LO + {5'h00, q.local_base_low, dec_sel_i}; // [RL4]
        end

        // external bus sequence
        case (q.xs)
            dms_pkg::XS_IDLE: begin
                if (ext_req_i) begin
                    if (win_rd) begin
                        n.xrdata = code_rdata_i; // [RL6]
                        n.xdone  = 1'b1;
                    end else if (!q.pin_en) begin
                        n.xrdata = 8'h00;        // pins not in memory function
                        n.xdone  = 1'b1;
                    end else begin
                        n.xaddr  = ext_addr_i;   // [RL5]
                        n.xwe    = ext_we_i;
                        n.xwdata = ext_wdata_i;
                        n.xs     = dms_pkg::XS_ALE;
                    end
                end
            end
            dms_pkg::XS_ALE: begin
                n.xs   = dms_pkg::XS_STRB;
                n.xcnt = 4'(dms_pkg::STRB_CYC - 1);
            end
            dms_pkg::XS_STRB: begin
                if (q.xcnt == 4'h0) begin
                    if (!q.xwe) begin
                        n.xrdata = q.sync2;      // [RL5]
                    end
                    n.xdone = 1'b1;
                    n.xs    = dms_pkg::XS_IDLE;
                end else begin
                    n.xcnt = q.xcnt - 4'h1;
                end
            end
            default: n.xs = dms_pkg::XS_IDLE;
        endcase

        // apb setup phase latches read data and error
        if (psel && !penable) begin
            n.err   = 1'b0;
            n.rdata = 32'h0000_0000;
            case (paddr)
                dms_pkg::OFS_ACC:  n.rdata = {16'h0000, q.acc};
                dms_pkg::OFS_PSW:  n.rdata = {16'h0000, q.program_status_word};
                dms_pkg::OFS_STATUS_HIGH_BYTE: n.rdata = {24'h000000, q.program_status_word[15:8]}; // [RL13]
                dms_pkg::OFS_STATUS_LOW_BYTE: n.rdata = {24'h000000, q.program_status_word[7:0]};  // [RL13]
                dms_pkg::OFS_LRB:  n.rdata = {24'h000000, q.local_base_low};
                dms_pkg::OFS_CTRL: n.rdata = {30'h0, q.pin_en, q.win_en};
                dms_pkg::OFS_STAT: n.rdata = {29'h0, dd_eff, q.dd_pend, ext_busy_o};
                default:           n.err   = 1'b1;
            endcase
        end

        // apb access phase writes
        if (apb_wr) begin
            case (paddr)
                dms_pkg::OFS_ACC: n.acc = pwdata[15:0];
                dms_pkg::OFS_PSW, dms_pkg::OFS_STATUS_HIGH_BYTE, dms_pkg::OFS_STATUS_LOW_BYTE: begin
                    if (paddr != dms_pkg::OFS_STATUS_LOW_BYTE) begin
                        n.program_status_word[15:8] = pwdata[7:0] | (paddr == dms_pkg::OFS_PSW ? pwdata[15:8] : 8'h00);
                    end
                    if (paddr == dms_pkg::OFS_PSW) begin
                        n.program_status_word[15:8] = pwdata[15:8];
                        n.program_status_word[7:0]  = pwdata[7:0];
                    end
                    if (paddr == dms_pkg::OFS_STATUS_LOW_BYTE) begin
                        n.program_status_word[7:0] = pwdata[7:0]; // [RL13]
                    end
                    if (paddr != dms_pkg::OFS_STATUS_LOW_BYTE) begin
                        n.dd_pend = 1'b1;        // [RL22]
                        n.dd_old  = dd_eff;
                    end
                end
                dms_pkg::OFS_LRB: n.local_base_low = pwdata[7:0]; // [RL4]
                dms_pkg::OFS_CTRL: begin
                    n.win_en = pwdata[0];        // [RL6]
                    n.pin_en = pwdata[1];        // [RL5]
                end
                default: n.err = q.err;
            endcase
        end

        // reset sources other than the pin
        if (reset_src_i) begin
            n.acc     = dms_pkg::RST_ACC;        // [RL12]
            n.program_status_word     = dms_pkg::RST_PSW;        // [RL14]
            n.dd_pend = 1'b0;
        end
    end

    // ***************************************
    // registers
    // ***************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            q     <= '0;                         // [RL12] [RL14]
            q.xs  <= dms_pkg::XS_IDLE;
        end else begin
            q <= n;
        end
    end

    // ***************************************
    // outputs
    // ***************************************
    assign prdata        = q.rdata;
    assign pready        = 1'b1;
    assign pslverr       = psel && penable && q.err;
    assign result_o      = q.res;
    assign bit_off_o     = q.acc[7:3];           // [RL11]
    assign bit_idx_o     = q.acc[2:0];           // [RL11]
    assign nibble_o      = q.acc[3:0];           // [RL10]
    assign width_o       = dd_eff;
    assign region_o      = q.region;
    assign dec_addr_o    = q.daddr;
    assign dec_addr_hi_o = q.daddr_hi;
    assign pr_addr_o     = q.pr_addr;
    assign lr_addr_o     = q.lr_addr;
    assign ext_busy_o    = (q.xs != dms_pkg::XS_IDLE);
    assign ext_done_o    = q.xdone;
    assign ext_rdata_o   = q.xrdata;
    assign mad_o         = (q.xs == dms_pkg::XS_ALE) ? q.xaddr[7:0] : q.xwdata; // [RL5]
    assign mad_oe_o      = (q.xs == dms_pkg::XS_ALE) || ((q.xs == dms_pkg::XS_STRB) && q.xwe);
    assign high_addr_o   = q.xaddr[15:8];
    assign ale_o         = (q.xs == dms_pkg::XS_ALE);
    assign rd_b_o        = !((q.xs == dms_pkg::XS_STRB) && !q.xwe);
    assign wr_b_o        = !((q.xs == dms_pkg::XS_STRB) && q.xwe);

    // ***************************************
    // assertions
    // ***************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    acc_clear_a: assert property (reset_src_i |=> q.acc == 16'h0000) // [RL12]
        else $error("acc not cleared by reset source");
    psw_clear_a: assert property (reset_src_i |=> q.program_status_word == 16'h0000) // [RL14]
        else $error("status not cleared by reset source");
    word_align_a: assert property (dec_valid_i && dec_word_i && !dec_code_i |=> // [RL8]
        dec_addr_o == {$past(dec_addr_i[15:1]), 1'b0} && dec_addr_hi_o[0])
        else $error("data word not aligned");
    code_any_a: assert property (dec_valid_i && dec_code_i |=> // [RL9]
        dec_addr_o == $past(dec_addr_i))
        else $error("program word address altered");
    window_read_a: assert property (ext_req_i && !ext_busy_o && win_rd |=> // [RL6]
        ext_done_o && ext_rdata_o == $past(code_rdata_i) && !ext_busy_o)
        else $error("window read not served from code");
    dd_load_a: assert property (op_valid_i && op == dms_pkg::OP_LOAD && !apb_wr // [RL21]
        && !reset_src_i |=> q.program_status_word[dms_pkg::B_DD] == $past(op_word_i) && width_o == $past(op_word_i))
        else $error("load did not set width");
    dd_lag_a: assert property (apb_wr && paddr == dms_pkg::OFS_PSW && !op_valid_i // [RL22]
        && !reset_src_i |=> width_o == $past(dd_eff))
        else $error("direct width write seen too early");
    irq_restore_a: assert property (op_valid_i && op == dms_pkg::OP_RETI && !apb_wr // [RL15]
        && !reset_src_i |=> q.program_status_word == $past(q.psw_save))
        else $error("status not restored");
    strobe_len_a: assert property ($fell(rd_b_o) |-> $past(ale_o) ##0 // [RL5]
        (!rd_b_o && ale_o == 1'b0)[*4] ##1 rd_b_o)
        else $error("read strobe length wrong");

    ext_rd_c: cover property ($rose(rd_b_o) ##1 ext_done_o);
    ext_wr_c: cover property ($fell(wr_b_o));
    win_c:    cover property (ext_req_i && win_rd && !ext_busy_o);
    reti_c:   cover property (op_valid_i && op == dms_pkg::OP_RETI);

endmodule

// ===== test/dms_mem.sv
// external byte memory on the muxed address/data bus
`timescale 1ns/1ps
module dms_mem (
    input  wire logic       clk_sys_i,   // system clock
    input  wire logic [7:0] mad_o,       // bus from core
    input  wire logic       mad_oe_o,    // core drives bus
    input  wire logic [7:0] high_addr_o, // high address
    input  wire logic       ale_o,       // latch strobe
    input  wire logic       rd_b_o,      // read strobe, low active
    input  wire logic       wr_b_o,      // write strobe, low active
    output logic      [7:0] mad_i        // bus to core
);
    logic [15:0] addr_q;
    logic [7:0]  mem [0:255];
    initial mad_i = 8'h00;
    // latch address, store on write, answer on read; a released bus toggles
    always @(posedge clk_sys_i) begin
        if (ale_o) addr_q <= {high_addr_o, mad_o};
        if (!wr_b_o && mad_oe_o) mem[addr_q[7:0]] <= mad_o;
        mad_i <= !rd_b_o ? mem[addr_q[7:0]] : ~mad_i;
    end
endmodule

// ===== test/test_dms_core.sv
// self-checking bench of the data map, accumulator and status block
`timescale 1ns/1ps
module test_dms_core;
    logic clk_sys_i=0, rst_b_i=0, reset_src_i=0, psel=0, penable=0, pwrite=0, op_valid_i=0, op_word_i=0;
    logic dec_valid_i=0, dec_word_i=0, dec_code_i=0, ext_req_i=0, ext_we_i=0, pready, pslverr, mad_oe_o;
    logic ale_o, rd_b_o, wr_b_o, ext_done_o, width_o, ext_busy_o;
    logic [15:0] dec_addr_hi_o;
    logic [7:0] paddr=0, ext_wdata_i=0, code_rdata_i=0, mad_i, mad_o, high_addr_o, ext_rdata_o;
    logic [31:0] pwdata=0, prdata, rd;
    logic [15:0] operand_i=0, dec_addr_i=0, ext_addr_i=0, result_o, dec_addr_o, pr_addr_o, lr_addr_o;
    logic [3:0] op_code_i=0, nibble_o;
    logic [4:0] region_o, bit_off_o;
    logic [2:0] dec_sel_i=0, bit_idx_o;
    logic er;
    int bad_count=0, n_compared=0;
    dms_core uut(.clk_sys_i, .rst_b_i, .reset_src_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .op_valid_i, .op_code_i, .op_word_i, .operand_i, .result_o, .bit_off_o, .bit_idx_o,
        .nibble_o, .width_o, .dec_valid_i, .dec_addr_i, .dec_word_i, .dec_code_i, .dec_sel_i, .region_o,
        .dec_addr_o, .dec_addr_hi_o, .pr_addr_o, .lr_addr_o, .ext_req_i, .ext_we_i, .ext_addr_i, .ext_wdata_i,
        .code_rdata_i, .ext_busy_o, .ext_done_o, .ext_rdata_o, .mad_i, .mad_o, .mad_oe_o, .high_addr_o,
        .ale_o, .rd_b_o, .wr_b_o);
    dms_mem mem(.clk_sys_i, .mad_o, .mad_oe_o, .high_addr_o, .ale_o, .rd_b_o, .wr_b_o, .mad_i);
    // 25 MHz clock
    always #20 clk_sys_i = ~clk_sys_i;
    task stop_test;
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // apb transfer: setup, then access until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys_i) penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task op(input logic [3:0] c, input logic w, input logic [15:0] d);
        @(posedge clk_sys_i) {op_valid_i, op_code_i, op_word_i, operand_i} <= {1'b1, c, w, d};
        @(posedge clk_sys_i) op_valid_i <= 1'b0;
        #1;
    endtask
    task dc(input logic [15:0] a, input logic w, input logic c, input logic [2:0] s);
        @(posedge clk_sys_i) {dec_valid_i, dec_addr_i, dec_word_i, dec_code_i, dec_sel_i} <= {1'b1, a, w, c, s};
        @(posedge clk_sys_i) dec_valid_i <= 1'b0;
        #1;
    endtask
    task ex(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) {ext_req_i, ext_we_i, ext_addr_i, ext_wdata_i} <= {1'b1, w, a, d};
        @(posedge clk_sys_i) ext_req_i <= 1'b0;
        #1;
        for (int i = 0; i < 20 && ext_done_o !== 1'b1; i++) @(posedge clk_sys_i) #1;
        chk("done", 1, ext_done_o);
        chk("idle", 0, ext_busy_o);
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        apb(0, dms_pkg::OFS_ACC, 0); chk("acc rst", dms_pkg::RST_ACC, rd);
        apb(0, dms_pkg::OFS_PSW, 0); chk("psw rst", dms_pkg::RST_PSW, rd);
        op(dms_pkg::OP_LOAD, 0, 16'h007f); chk("views", 12'h7ff, {bit_off_o, bit_idx_o, nibble_o});
        op(dms_pkg::OP_ADD, 0, 16'h0001); chk("byte add", 16'h0080, result_o);
        apb(0, dms_pkg::OFS_PSW, 0); chk("psw add", 16'h2a00, rd);
        op(dms_pkg::OP_ADD, 0, 16'h0080); apb(0, dms_pkg::OFS_STATUS_HIGH_BYTE, 0); chk("psw cy", 8'hc2, rd);
        op(dms_pkg::OP_SETW, 0, 0); op(dms_pkg::OP_ADD, 0, 16'h8000); chk("word add", 16'h8000, result_o);
        chk("width", 1, width_o);
        apb(0, dms_pkg::OFS_PSW, 0); chk("psw word", 16'h1800, rd);
        apb(1, dms_pkg::OFS_PSW, 32'h0103); op(dms_pkg::OP_IRQ, 0, 0); op(dms_pkg::OP_RETI, 0, 0);
        apb(0, dms_pkg::OFS_PSW, 0); chk("reti", 16'h0103, rd);
        dc(16'h0335, 1, 0, 1); chk("word", 16'h0334, dec_addr_o);
        chk("word hi", 16'h0335, dec_addr_hi_o);
        chk("pr", {16'h021a, dms_pkg::RG_RAM}, {pr_addr_o, region_o});
        dc(16'h0335, 0, 0, 0); chk("byte", 16'h0335, dec_addr_o);
        dc(16'h0335, 1, 1, 0); chk("code", 16'h0335, dec_addr_o);
        dc(16'h02c0, 0, 0, 0); chk("sba", dms_pkg::RG_SBA, region_o);
        dc(16'h0a00, 0, 0, 0); chk("ext", dms_pkg::RG_EXT, region_o);
        apb(1, dms_pkg::OFS_LRB, 2); dc(16'h09ff, 0, 0, 5); chk("lr", {16'h0215, dms_pkg::RG_RAM}, {lr_addr_o, region_o});
        apb(1, dms_pkg::OFS_CTRL, 2); ex(1, 16'h0a34, 8'h96); ex(0, 16'h0a34, 0); chk("ext rd", 8'h96, ext_rdata_o);
        code_rdata_i <= 8'hc3; apb(1, dms_pkg::OFS_CTRL, 3); ex(0, 16'h1000, 0); chk("window", 8'hc3, ext_rdata_o);
        @(posedge clk_sys_i) reset_src_i <= 1'b1;
        @(posedge clk_sys_i) reset_src_i <= 1'b0;
        apb(0, dms_pkg::OFS_ACC, 0); chk("acc src", 0, rd);
        apb(0, dms_pkg::OFS_PSW, 0); chk("psw src", 0, rd);
        apb(0, 8'h40, 0); chk("unmapped", 1, er);
        stop_test;
    end
    // watchdog
    initial begin
        #400000;
        bad_count++;
        stop_test;
    end
endmodule
